/* File: rtl/rsts_consts.svh */
// Register offsets, field positions and reset values of the status and test register group
`ifndef RSTS_CONSTS_SVH
`define RSTS_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RSTS_ADDR_GAIN_STATUS 8'h0e
`define RSTS_ADDR_SIG_STRENGTH 8'h0f
`define RSTS_ADDR_PAGED_STATUS 8'h10
`define RSTS_ADDR_MEAS_SEL 8'h11
`define RSTS_ADDR_TEST_SETTING 8'h12
`define RSTS_ADDR_VERSION 8'h13
`define RSTS_ADDR_CTRL 8'h20

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define RSTS_PAGE_EXT_BIT 16
`define RSTS_PAGE_HI 15
`define RSTS_PAGE_LO 14
`define RSTS_MEAS_SEL_RESET 8'h00
`define RSTS_MEAS_SEL_WMASK 8'h0f
`define RSTS_TEST_RESET 24'h000000
`define RSTS_VERSION_CODE 8'h5a
`define RSTS_RDATA_IDLE 24'h000000

`endif

/* File: rtl/rsts_pkg.sv */
// Types shared by the status and test register group
package rsts_pkg;
  typedef enum logic [2:0] {
    RSTS_PAGE_LIMITER,
    RSTS_PAGE_OSC,
    RSTS_PAGE_FILTER_CAL,
    RSTS_PAGE_PILOT,
    RSTS_PAGE_RSV4,
    RSTS_PAGE_RSV5,
    RSTS_PAGE_RSV6,
    RSTS_PAGE_RSV7
  } rsts_page_t;

  typedef enum logic [2:0] {
    RSTS_MEAS_NONE = 3'h0,
    RSTS_MEAS_MIXER_A = 3'h1,
    RSTS_MEAS_RSV2 = 3'h2,
    RSTS_MEAS_ADC_PIN = 3'h3,
    RSTS_MEAS_RF_LEVEL = 3'h4,
    RSTS_MEAS_RSV5 = 3'h5,
    RSTS_MEAS_RSV6 = 3'h6,
    RSTS_MEAS_EXT_SUPPLY = 3'h7
  } rsts_meas_t;
endpackage

/* File: rtl/rsts_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module rsts_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A bit only moves once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (!rstn) begin
          sync_out[i] <= 1'b0;
        end else if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  endgenerate
endmodule

/* File: rtl/rsts_regs.sv */
// Status and test register group of the reader front end
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`include "rsts_consts.svh"

// Function
// - Gain step appears in bits 6..4 of the internal status register.
// - Bit 3 shows decoder source channel, tracked over reception and held from transmit until next reception.
// - Signal strength: channel B in upper nibble, channel A in lower.
// - Signal strength captured over reception, frozen once transmission starts.
// - Page 0 shows limiter levels A in bits 5..3, B in 2..0.
// - Page 1 shows oscillator range, type and pin voltage.
// - Page 2 shows highpass trim upper nibble, lowpass trim lower nibble.
// - Page 3 shows the eight-bit pilot frequency count.
// - Page number is test bit 16 above bits 15..14.
// - Measurement selector low code routes the converter source.
// - Measurement selector clears on reset or while chip enable is low.
module rsts_regs #(
  parameter logic [7:0] VERSION_CODE = `RSTS_VERSION_CODE // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [23:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [23:0] rdata,
  input wire logic chip_en,
  input wire logic rx_start,
  input wire logic tx_start,
  input wire logic [2:0] gain_step,
  input wire logic in_select,
  input wire logic rf_ok,
  input wire logic pll_ok,
  input wire logic osc_ok,
  input wire logic [3:0] sig_level_a,
  input wire logic [3:0] sig_level_b,
  input wire logic [2:0] limiter_a,
  input wire logic [2:0] limiter_b,
  input wire logic [3:0] osc_range_info,
  input wire logic osc_type,
  input wire logic [2:0] osc_pin_volt,
  input wire logic [3:0] highpass_trim,
  input wire logic [3:0] lowpass_trim,
  input wire logic [7:0] pilot_freq,
  output logic [2:0] adc_src,
  output logic [2:0] status_page_sel,
  output logic [23:0] test_bits,
  output logic rx_window
);

  // ****************************************************************
  // Chip enable from pin
  // ****************************************************************
  logic chip_en_s;

  rsts_sync #(.WIDTH(1)) u_en_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .async_in(chip_en),
    .sync_out(chip_en_s)
  );

  // ****************************************************************
  // Reception window and captured status
  // ****************************************************************
  logic [7:0] gain_status;
  logic [7:0] sig_strength;
  logic [7:0] meas_sel;
  logic [23:0] test_setting;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rx_window <= 1'b0;
    end else if (tx_start) begin
      rx_window <= 1'b0;
    end else if (rx_start) begin
      rx_window <= 1'b1;
    end
  end

  // Track live during reception; freeze at transmit so host sees last values
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sig_strength <= 8'h00;
    end else if ((rx_window || rx_start) && !tx_start) begin
      sig_strength <= {sig_level_b, sig_level_a};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      gain_status <= 8'h00;
    end else begin
      gain_status[7] <= 1'b0;
      gain_status[6:4] <= gain_step;
      gain_status[2:0] <= {rf_ok, pll_ok, osc_ok};
      if ((rx_window || rx_start) && !tx_start) begin
        gain_status[3] <= in_select;
      end
    end
  end

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rstn || !chip_en_s) begin
      meas_sel <= `RSTS_MEAS_SEL_RESET;
    end else if (wr_stb && addr == `RSTS_ADDR_MEAS_SEL) begin
      meas_sel <= wdata[7:0] & `RSTS_MEAS_SEL_WMASK;
    end
  end

  // Reserved bits are stored as written; zeroing them is the host's duty
  always_ff @(posedge clk_sys) begin
    if (!rstn || !chip_en_s) begin
      test_setting <= `RSTS_TEST_RESET;
    end else if (wr_stb && addr == `RSTS_ADDR_TEST_SETTING) begin
      test_setting <= wdata;
    end
  end

  assign status_page_sel = {test_setting[`RSTS_PAGE_EXT_BIT],
                            test_setting[`RSTS_PAGE_HI:`RSTS_PAGE_LO]};
  assign adc_src = meas_sel[2:0];
  assign test_bits = test_setting;

  // ****************************************************************
  // Paged status byte
  // ****************************************************************
  function automatic logic [7:0] page_byte(input logic [2:0] page);
    logic [7:0] b;
    b = 8'h00;
    case (rsts_pkg::rsts_page_t'(page))
      rsts_pkg::RSTS_PAGE_LIMITER: begin
        b = {2'b00, limiter_a, limiter_b};
      end
      rsts_pkg::RSTS_PAGE_OSC: begin
        b = {osc_range_info, osc_type, osc_pin_volt};
      end
      rsts_pkg::RSTS_PAGE_FILTER_CAL: begin
        b = {highpass_trim, lowpass_trim};
      end
      rsts_pkg::RSTS_PAGE_PILOT: begin
        b = pilot_freq;
      end
      default: begin
        b = 8'h00;
      end
    endcase
    return b;
  endfunction

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Unmapped addresses and idle cycles read zero
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdata <= `RSTS_RDATA_IDLE;
    end else if (!rd_stb) begin
      rdata <= `RSTS_RDATA_IDLE;
    end else if (addr == `RSTS_ADDR_GAIN_STATUS) begin
      rdata <= {16'h0000, gain_status};
    end else if (addr == `RSTS_ADDR_SIG_STRENGTH) begin
      rdata <= {16'h0000, sig_strength};
    end else if (addr == `RSTS_ADDR_PAGED_STATUS) begin
      rdata <= {16'h0000, page_byte(status_page_sel)};
    end else if (addr == `RSTS_ADDR_MEAS_SEL) begin
      rdata <= {16'h0000, meas_sel};
    end else if (addr == `RSTS_ADDR_TEST_SETTING) begin
      rdata <= test_setting;
    end else if (addr == `RSTS_ADDR_VERSION) begin
      rdata <= {16'h0000, VERSION_CODE};
    end else begin
      rdata <= `RSTS_RDATA_IDLE;
    end
  end

endmodule

/* File: test/rsts_regs_asserts.sv */
// Checker of the status and test register group ports
`timescale 1ns/100ps
module rsts_regs_chk #(
  parameter logic [7:0] VERSION_CODE = 8'h5a
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic rd_stb,
  input wire logic [23:0] rdata,
  input wire logic rx_start,
  input wire logic tx_start,
  input wire logic rx_window,
  input wire logic [2:0] status_page_sel,
  input wire logic [23:0] test_bits,
  input wire logic [2:0] adc_src,
  input wire logic [2:0] limiter_a,
  input wire logic [2:0] limiter_b,
  input wire logic [7:0] pilot_freq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_rd(a);
    rd_stb && addr == a;
  endsequence
  property p_ver; s_rd(8'h13) |=> rdata == {16'h0, VERSION_CODE}; endproperty
  a_ver: assert property (p_ver) else $error("version read wrong");
  property p_idle; !rd_stb |=> rdata == 24'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_pg; status_page_sel == {test_bits[16], test_bits[15:14]}; endproperty
  a_pg: assert property (p_pg) else $error("page select wrong");
  property p_ms; s_rd(8'h11) |=> rdata[2:0] == $past(adc_src) && rdata[23:4] == 20'h0; endproperty
  a_ms: assert property (p_ms) else $error("selector read wrong");
  // Page bytes are sampled at the strobe edge
  property p_p0;
    s_rd(8'h10) ##0 status_page_sel == 3'h0 |=>
      rdata == {18'h0, $past(limiter_a), $past(limiter_b)};
  endproperty
  a_p0: assert property (p_p0) else $error("page 0 wrong");
  property p_p3; s_rd(8'h10) ##0 status_page_sel == 3'h3 |=> rdata == {16'h0, $past(pilot_freq)}; endproperty
  a_p3: assert property (p_p3) else $error("page 3 wrong");
  property p_rxo; rx_start && !tx_start |=> rx_window; endproperty
  a_rxo: assert property (p_rxo) else $error("window not opened");
  // A fresh rx_start right after transmit may legally reopen the window
  property p_rxc; tx_start |=> !rx_window ##1 (!rx_window || $past(rx_start)); endproperty
  a_rxc: assert property (p_rxc) else $error("window not closed");
endmodule
bind rsts_regs rsts_regs_chk #(.VERSION_CODE(VERSION_CODE)) rsts_regs_chk_inst (
  .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .rd_stb(rd_stb), .rdata(rdata),
  .rx_start(rx_start), .tx_start(tx_start), .rx_window(rx_window),
  .status_page_sel(status_page_sel), .test_bits(test_bits), .adc_src(adc_src),
  .limiter_a(limiter_a), .limiter_b(limiter_b), .pilot_freq(pilot_freq)
);

/* File: test/tb.sv */
// Self-checking bench of the status and test register group
`timescale 1ns/100ps
`include "rsts_consts.svh"
module tb;
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic wr_stb = 1'h0;
  logic rd_stb = 1'h0;
  logic chip_en = 1'h0;
  logic rx_start = 1'h0;
  logic tx_start = 1'h0;
  logic [7:0] addr = 8'h0;
  logic [23:0] wdata = 24'h0;
  logic [44:0] live = '0;
  logic [2:0] gain_step, limiter_a, limiter_b, osc_pin_volt, adc_src, status_page_sel, p;
  logic [3:0] sig_level_a, sig_level_b, osc_range_info, highpass_trim, lowpass_trim;
  logic [7:0] pilot_freq;
  logic in_select, rf_ok, pll_ok, osc_ok, osc_type, rx_window, ib;
  logic [23:0] rdata, test_bits, d, s;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  // ****************************************************************
  // Design and live sources
  // ****************************************************************
  assign {gain_step, in_select, rf_ok, pll_ok, osc_ok, sig_level_a, sig_level_b, limiter_a,
    limiter_b, osc_range_info, osc_type, osc_pin_volt, highpass_trim, lowpass_trim,
    pilot_freq} = live;
  rsts_regs rsts_regs_inst (.clk_sys, .rstn, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .chip_en, .rx_start, .tx_start, .gain_step, .in_select, .rf_ok, .pll_ok, .osc_ok,
    .sig_level_a, .sig_level_b, .limiter_a, .limiter_b, .osc_range_info, .osc_type,
    .osc_pin_volt, .highpass_trim, .lowpass_trim, .pilot_freq, .adc_src,
    .status_page_sel, .test_bits, .rx_window);
  always #5 clk_sys = ~clk_sys;
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_sim;
    $display("checks %0d bad %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input logic [23:0] v, x);
    samples_checked++;
    if (v !== x) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, v, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] w);
    @(posedge clk_sys);
    wr_stb <= 1'h1;
    addr <= a;
    wdata <= w;
    @(posedge clk_sys);
    wr_stb <= 1'h0;
    #1;
  endtask
  // Read data stand one cycle only, so sample just after that edge
  task automatic rc(input logic [7:0] a, input logic [23:0] x);
    @(posedge clk_sys);
    rd_stb <= 1'h1;
    addr <= a;
    @(posedge clk_sys);
    rd_stb <= 1'h0;
    #1;
    chk(rdata, x);
  endtask
  task automatic rnd;
    @(posedge clk_sys);
    live <= 45'({$urandom, $urandom});
    #1;
  endtask
  function automatic logic [23:0] pg(input logic [2:0] n);
    case (n)
      3'h0: pg = {18'h0, limiter_a, limiter_b};
      3'h1: pg = {16'h0, osc_range_info, osc_type, osc_pin_volt};
      3'h2: pg = {16'h0, highpass_trim, lowpass_trim};
      3'h3: pg = {16'h0, pilot_freq};
      default: pg = 24'h0;
    endcase
  endfunction
  task automatic pulse(input logic t);
    @(posedge clk_sys);
    if (t) tx_start <= 1'h1;
    else rx_start <= 1'h1;
    @(posedge clk_sys);
    {rx_start, tx_start} <= 2'h0;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    d = 24'($urandom(32'h1f327d43));
    repeat (16) @(posedge clk_sys);
    rstn <= 1'h1;
    rc(8'h11, 24'h0);
    rc(8'h13, 24'(`RSTS_VERSION_CODE));
    wr(8'h13, 24'h0);
    rc(8'h13, 24'(`RSTS_VERSION_CODE));
    rc(8'h20, 24'h0);
    chip_en <= 1'h1;
    repeat (6) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      d = 24'($urandom);
      d[2:0] = i[2:0];
      wr(8'h11, d);
      chk(24'(adc_src), 24'(i[2:0]));
      rc(8'h11, d & 24'h0f);
    end
    chip_en <= 1'h0;
    repeat (6) @(posedge clk_sys);
    wr(8'h11, 24'h7);
    rc(8'h11, 24'h0);
    $display("selector test done");
    chip_en <= 1'h1;
    repeat (6) @(posedge clk_sys);
    for (int i = 0; i < 16; i++) begin
      rnd();
      p = i[2:0];
      wr(8'h12, {7'h0, p, 14'h0});
      chk(24'(status_page_sel), 24'(p));
      chk(test_bits, {7'h0, p, 14'h0});
      rc(8'h12, {7'h0, p, 14'h0});
      rc(8'h10, pg(p));
    end
    wr(8'h12, 24'h0);
    $display("page test done");
    rnd();
    pulse(1'h0);
    repeat (3) @(posedge clk_sys);
    chk(24'(rx_window), 24'h1);
    s = {16'h0, sig_level_b, sig_level_a};
    ib = in_select;
    rc(8'h0f, s);
    rc(8'h0e, {17'h0, gain_step, in_select, rf_ok, pll_ok, osc_ok});
    pulse(1'h1);
    rnd();
    repeat (3) @(posedge clk_sys);
    chk(24'(rx_window), 24'h0);
    rc(8'h0f, s);
    rc(8'h0e, {17'h0, gain_step, ib, rf_ok, pll_ok, osc_ok});
    $display("strength test done");
    end_sim();
  end
endmodule
